// file: logic/drive_mon_map.svh
/*
 * constants of the drive supervisory logic: sentinels, limits, timing.
 * assumes a 40 MHz control clock; frequencies in 0.01 Hz units,
 * times in 0.1 s units, band in whole percent.
 */
`ifndef DRIVE_MON_MAP_SVH
`define DRIVE_MON_MAP_SVH

// ****************************************************************
// configuration codes
// ****************************************************************
`define CFG_UNSET 16'h270F
`define MON_SRC_CURRENT 1'h1
`define BAND_PCT_MAX 8'h64
`define PCT_SCALE 24'h000064

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 40000000
`define TENTH_MS 100
`define TENTH_CYCLES (`CLK_HZ / 1000 * `TENTH_MS)
`define LOSS_HOLD_MS 200
`define LOSS_TENTHS (`LOSS_HOLD_MS / `TENTH_MS)
`define STD_WAIT_SMALL_MS 500
`define STD_WAIT_LARGE_MS 1000
`define STD_WAIT_SMALL_TENTHS (`STD_WAIT_SMALL_MS / `TENTH_MS)
`define STD_WAIT_LARGE_TENTHS (`STD_WAIT_LARGE_MS / `TENTH_MS)
`define TIME_MIN_TENTHS 8'h01
`define TIME_MAX_TENTHS 8'h32

// ****************************************************************
// monitor pulse train and voltage ramp
// ****************************************************************
`define MON_BASE_HZ 1440
`define MON_MAX_HZ 2400
`define VSCALE_FULL 11'h400

`endif

// file: logic/drive_mon_pkg.sv
/*
 * types shared by the drive supervisory logic.
 * assumes drive_mon_map.svh for the numeric constants.
 */
package drive_mon_pkg;

    // one parameter set in force for the ramp generator and modulator
    typedef struct packed {
        logic [15:0] accel_time;
        logic [15:0] decel_time;
        logic [15:0] torque_boost;
        logic [15:0] base_freq;
    } drive_set_t;

    // present measurements of the power stage
    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] set_freq;
        logic [15:0] out_current;
        logic reverse;
    } drive_meas_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_LOST = 5'h02,
        ST_COAST = 5'h04,
        ST_RAMP = 5'h08,
        ST_BLOCK = 5'h10
    } restart_state_t;

endpackage : drive_mon_pkg

// file: logic/pulse_rate_gen.sv
/*
 * pulse train whose rate is 1440 Hz when value equals reference,
 * proportional otherwise and never above 2400 Hz.
 * assumes value and reference share a unit; reference 0 stops output.
 */
`timescale 1ns/10ps
`include "drive_mon_map.svh"

module pulse_rate_gen (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [15:0] i_value,
    input wire logic [15:0] i_ref,
    output logic o_pulse
);

    logic [47:0] acc_reg;
    logic [47:0] acc_next;
    logic pulse_reg;
    logic pulse_next;
    wire logic [47:0] raw_step = 48'(i_value) * 48'(`MON_BASE_HZ);
    wire logic [47:0] cap_step = 48'(i_ref) * 48'(`MON_MAX_HZ);
    wire logic [47:0] step = (raw_step > cap_step) ? cap_step : raw_step;
    wire logic [47:0] half_thr = 48'(i_ref) * 48'(`CLK_HZ / 2);
    wire logic [47:0] acc_sum = acc_reg + step;
    wire logic wrap = (acc_sum >= half_thr);

    // toggle twice per period; a phase above a new reference restarts
    always_comb begin
        acc_next = acc_sum;
        pulse_next = pulse_reg;
        if (i_ref == 16'h0000) begin
            acc_next = 48'h0;
            pulse_next = 1'b0;
        end else if (wrap) begin
            acc_next = (acc_reg >= half_thr) ? 48'h0 : acc_sum - half_thr;
            pulse_next = ~pulse_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            acc_reg <= 48'h0;
            pulse_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            pulse_reg <= pulse_next;
        end
    end

    assign o_pulse = pulse_reg;

endmodule : pulse_rate_gen

// file: logic/drive_freq_monitor_restart.sv
/*
 * supervisory logic of a motor inverter: frequency arrival and sensing
 * outputs, second parameter set, pulse monitor, restart after brief
 * supply loss. assumes measurements and i_update come from logic on
 * i_clk; terminal and supply pins are asynchronous.
 */
`timescale 1ns/10ps
`include "drive_mon_map.svh"

// Operation
// - arrival flag when within configured band
// - sensing output conducts above level
// - reverse level used during reverse rotation
// - unset reverse level uses forward level
// - contact selects second ramp, boost, base
// - unset second decel reuses second accel
// - vector mode ignores boost and base
// - second times share ramp reference frequency
// - monitor source frequency or current
// - frequency reference gives 1440 Hz pulses
// - current reference gives 1440 Hz pulses
// - monitor pulse rate capped at 2400 Hz
// - restart holds frequency, ramps voltage
// - loss over 0.2 s restarts from zero
// - unset coast time disables restart
// - zero coast time uses rating standard wait
// - voltage ramps over configured start-up time
// - shared terminal defaults to output shutoff
module drive_freq_monitor_restart #(
    parameter int unsigned TENTH_CYCLES = `TENTH_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_update,
    input wire drive_mon_pkg::drive_meas_t i_meas,
    input wire logic [7:0] i_arrival_band_width,
    input wire logic [15:0] i_fwd_sense_level,
    input wire logic [15:0] i_rev_sense_level,
    input wire drive_mon_pkg::drive_set_t i_main_set,
    input wire logic [15:0] i_alt_accel_time,
    input wire logic [15:0] i_alt_decel_time,
    input wire logic [15:0] i_alt_torque_boost,
    input wire logic [15:0] i_alt_base_freq,
    input wire logic [15:0] i_ramp_reference_freq,
    input wire logic i_vector_mode_select,
    input wire logic i_shared_term_pin,
    input wire logic i_term_as_second_set,
    input wire logic i_monitor_source_select,
    input wire logic [15:0] i_freq_monitor_reference,
    input wire logic [15:0] i_current_monitor_reference,
    input wire logic i_supply_ok_pin,
    input wire logic i_rating_large,
    input wire logic [15:0] i_coast_wait_time,
    input wire logic [15:0] i_voltage_ramp_time,
    input wire logic i_restart_clear,
    output logic o_freq_arrived_flag_o,
    output logic o_freq_arrived_flag_oe,
    output logic o_freq_detect_flag_o,
    output logic o_freq_detect_flag_oe,
    output logic o_second_set_select,
    output logic o_output_shutoff_in,
    output drive_mon_pkg::drive_set_t o_drive_set,
    output logic [15:0] o_ramp_reference_freq,
    output logic o_pulse_monitor_out,
    output logic [15:0] o_restart_freq,
    output logic [10:0] o_voltage_scale,
    output logic o_restart_active,
    output logic o_restart_blocked
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic is_unset(input logic [15:0] v);
        is_unset = (v == `CFG_UNSET);
    endfunction : is_unset

    function automatic logic [7:0] clamp_tenths(input logic [15:0] v);
        if (v > 16'(`TIME_MAX_TENTHS))
            clamp_tenths = `TIME_MAX_TENTHS;
        else if (v < 16'(`TIME_MIN_TENTHS))
            clamp_tenths = `TIME_MIN_TENTHS;
        else
            clamp_tenths = v[7:0];
    endfunction : clamp_tenths

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] term_sync_reg;
    logic [2:0] supply_sync_reg;
    logic term_reg;
    logic supply_reg;

    // a pin level counts once the second and third stages agree
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            term_sync_reg <= 3'h0;
            supply_sync_reg <= 3'h7;
            term_reg <= 1'b0;
            supply_reg <= 1'b1;
        end else begin
            term_sync_reg <= {term_sync_reg[1:0], i_shared_term_pin};
            supply_sync_reg <= {supply_sync_reg[1:0], i_supply_ok_pin};
            if (term_sync_reg[1] == term_sync_reg[2])
                term_reg <= term_sync_reg[2];
            if (supply_sync_reg[1] == supply_sync_reg[2])
                supply_reg <= supply_sync_reg[2];
        end
    end

    // ****************************************************************
    // frequency arrival and sensing
    // ****************************************************************
    wire logic [15:0] freq_diff = (i_meas.out_freq > i_meas.set_freq) ?
        (i_meas.out_freq - i_meas.set_freq) :
        (i_meas.set_freq - i_meas.out_freq);
    wire logic [7:0] band_pct = (i_arrival_band_width > `BAND_PCT_MAX) ?
        `BAND_PCT_MAX : i_arrival_band_width;
    wire logic [23:0] band_lim = 24'(i_meas.set_freq) * 24'(band_pct);
    wire logic [23:0] diff_pct = 24'(freq_diff) * `PCT_SCALE;
    wire logic in_band = (diff_pct <= band_lim);
    wire logic use_rev = i_meas.reverse &&
        !is_unset(i_rev_sense_level);
    wire logic [15:0] sense_lvl = use_rev ? i_rev_sense_level :
        i_fwd_sense_level;
    wire logic above_lvl = (i_meas.out_freq > sense_lvl);

    logic arrived_reg;
    logic detect_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            arrived_reg <= 1'b0;
            detect_reg <= 1'b0;
        end else if (i_update) begin
            arrived_reg <= in_band;
            detect_reg <= above_lvl;
        end
    end

    // open-collector: enable high means the output conducts
    assign o_freq_arrived_flag_o = 1'b0;
    assign o_freq_arrived_flag_oe = arrived_reg;
    assign o_freq_detect_flag_o = 1'b0;
    assign o_freq_detect_flag_oe = detect_reg;

    a_detect_fwd_lvl: assert property (i_update && !i_meas.reverse |=>
        o_freq_detect_flag_oe == ($past(i_meas.out_freq) >
        $past(i_fwd_sense_level)))
        else $error("forward sensing level not applied");
    a_detect_rev_lvl: assert property (i_update && i_meas.reverse &&
        i_rev_sense_level != `CFG_UNSET |=> o_freq_detect_flag_oe ==
        ($past(i_meas.out_freq) > $past(i_rev_sense_level)))
        else $error("reverse sensing level not applied");
    a_detect_unset_rev: assert property (i_update && i_meas.reverse &&
        i_rev_sense_level == `CFG_UNSET |=> o_freq_detect_flag_oe ==
        ($past(i_meas.out_freq) > $past(i_fwd_sense_level)))
        else $error("unset reverse level not using forward");
    a_arrival_exact: assert property (i_update &&
        i_meas.out_freq == i_meas.set_freq |=> o_freq_arrived_flag_oe)
        else $error("arrival missing at set frequency");
    a_flags_hold: assert property (!i_update |=>
        $stable(o_freq_detect_flag_oe) && $stable(o_freq_arrived_flag_oe))
        else $error("flags changed without an update");

    // ****************************************************************
    // second parameter set
    // ****************************************************************
    wire logic second_sel = term_reg && i_term_as_second_set;
    wire logic shutoff = term_reg && !i_term_as_second_set;
    wire logic [15:0] alt_decel = is_unset(i_alt_decel_time) ?
        i_alt_accel_time : i_alt_decel_time;
    wire logic [15:0] boost_sel = second_sel ? i_alt_torque_boost :
        i_main_set.torque_boost;
    wire logic [15:0] base_sel = second_sel ? i_alt_base_freq :
        i_main_set.base_freq;

    drive_mon_pkg::drive_set_t set_reg;
    drive_mon_pkg::drive_set_t set_next;
    logic second_reg;
    logic shutoff_reg;

    always_comb begin
        set_next.accel_time = second_sel ? i_alt_accel_time :
            i_main_set.accel_time;
        set_next.decel_time = second_sel ? alt_decel :
            i_main_set.decel_time;
        set_next.torque_boost = i_vector_mode_select ? 16'h0000 :
            boost_sel;
        set_next.base_freq = i_vector_mode_select ? 16'h0000 :
            base_sel;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            set_reg <= '0;
            second_reg <= 1'b0;
            shutoff_reg <= 1'b0;
            o_ramp_reference_freq <= 16'h0000;
        end else begin
            set_reg <= set_next;
            second_reg <= second_sel;
            shutoff_reg <= shutoff;
            // both sets are timed against the one reference
            o_ramp_reference_freq <= i_ramp_reference_freq;
        end
    end

    assign o_drive_set = set_reg;
    assign o_second_set_select = second_reg;
    assign o_output_shutoff_in = shutoff_reg;

    a_alt_accel_sel: assert property (second_sel |=>
        o_drive_set.accel_time == $past(i_alt_accel_time))
        else $error("second acceleration time not selected");
    a_alt_decel_share: assert property (second_sel &&
        i_alt_decel_time == `CFG_UNSET |=>
        o_drive_set.decel_time == o_drive_set.accel_time)
        else $error("unset second decel not sharing accel");
    a_vector_ignore: assert property (i_vector_mode_select |=>
        o_drive_set.torque_boost == 16'h0000 &&
        o_drive_set.base_freq == 16'h0000)
        else $error("boost or base used in vector mode");
    a_shutoff_default: assert property (!i_term_as_second_set |=>
        !o_second_set_select)
        else $error("shared terminal selected second set");

    // ****************************************************************
    // pulse monitor
    // ****************************************************************
    wire logic mon_cur = (i_monitor_source_select == `MON_SRC_CURRENT);
    wire logic [15:0] mon_value = mon_cur ? i_meas.out_current :
        i_meas.out_freq;
    wire logic [15:0] mon_ref = mon_cur ? i_current_monitor_reference :
        i_freq_monitor_reference;

    // rate is 1440 Hz at the reference and never above 2400 Hz
    pulse_rate_gen i_pulse_rate_gen (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_value(mon_value),
        .i_ref(mon_ref),
        .o_pulse(o_pulse_monitor_out)
    );

    // ****************************************************************
    // restart after brief supply loss
    // ****************************************************************
    drive_mon_pkg::restart_state_t state_reg;
    drive_mon_pkg::restart_state_t state_next;
    logic [31:0] sub_reg;
    logic [7:0] tenths_reg;
    logic [15:0] held_reg;
    logic long_reg;
    logic [31:0] ramp_acc_reg;
    logic [10:0] vscale_reg;

    wire logic tenth_tick = (sub_reg == 32'(TENTH_CYCLES - 1));
    wire logic loss_long = (tenths_reg > 8'(`LOSS_TENTHS)) ||
        ((tenths_reg == 8'(`LOSS_TENTHS)) && (sub_reg != 32'h0));
    wire logic [7:0] std_wait = i_rating_large ?
        8'(`STD_WAIT_LARGE_TENTHS) : 8'(`STD_WAIT_SMALL_TENTHS);
    wire logic [7:0] coast_tenths = (i_coast_wait_time == 16'h0000) ?
        std_wait : clamp_tenths(i_coast_wait_time);
    wire logic [31:0] ramp_cycles =
        32'(clamp_tenths(i_voltage_ramp_time)) * 32'(TENTH_CYCLES);
    wire logic [31:0] ramp_sum = ramp_acc_reg + 32'(`VSCALE_FULL);
    wire logic ramp_step = (ramp_sum >= ramp_cycles);
    wire logic ramp_done = (vscale_reg == `VSCALE_FULL);
    wire logic ramp_over = (tenths_reg >= clamp_tenths(i_voltage_ramp_time));
    wire logic coast_done = (tenths_reg >= coast_tenths);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            drive_mon_pkg::ST_RUN: begin
                if (!supply_reg)
                    state_next = drive_mon_pkg::ST_LOST;
            end
            drive_mon_pkg::ST_LOST: begin
                if (supply_reg && is_unset(i_coast_wait_time))
                    state_next = drive_mon_pkg::ST_BLOCK;
                else if (supply_reg)
                    state_next = drive_mon_pkg::ST_COAST;
            end
            drive_mon_pkg::ST_COAST: begin
                if (!supply_reg)
                    state_next = drive_mon_pkg::ST_LOST;
                else if (coast_done)
                    state_next = drive_mon_pkg::ST_RAMP;
            end
            drive_mon_pkg::ST_RAMP: begin
                if (!supply_reg)
                    state_next = drive_mon_pkg::ST_LOST;
                else if (ramp_done)
                    state_next = drive_mon_pkg::ST_RUN;
            end
            drive_mon_pkg::ST_BLOCK: begin
                if (supply_reg && i_restart_clear)
                    state_next = drive_mon_pkg::ST_RUN;
            end
            default: state_next = drive_mon_pkg::ST_RUN;
        endcase
    end

    // state timer restarts on every state change
    always_ff @(posedge i_clk) begin
        if (i_srst || state_next != state_reg) begin
            sub_reg <= 32'h0;
            tenths_reg <= 8'h00;
        end else if (tenth_tick) begin
            sub_reg <= 32'h0;
            if (tenths_reg != 8'hFF)
                tenths_reg <= tenths_reg + 8'h01;
        end else begin
            sub_reg <= sub_reg + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= drive_mon_pkg::ST_RUN;
            held_reg <= 16'h0000;
            long_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == drive_mon_pkg::ST_RUN) begin
                held_reg <= i_meas.out_freq;
                long_reg <= 1'b0;
            end else if (state_reg == drive_mon_pkg::ST_LOST &&
                         loss_long) begin
                held_reg <= 16'h0000;
                long_reg <= 1'b1;
            end
        end
    end

    // linear voltage rise from zero to full over the start-up time
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ramp_acc_reg <= 32'h0;
            vscale_reg <= `VSCALE_FULL;
        end else if (state_reg == drive_mon_pkg::ST_RUN) begin
            ramp_acc_reg <= 32'h0;
            vscale_reg <= `VSCALE_FULL;
        end else if (state_reg == drive_mon_pkg::ST_RAMP) begin
            if (ramp_over) begin
                vscale_reg <= `VSCALE_FULL;
            end else if (ramp_step && !ramp_done) begin
                ramp_acc_reg <= ramp_sum - ramp_cycles;
                vscale_reg <= vscale_reg + 11'h001;
            end else if (!ramp_done) begin
                ramp_acc_reg <= ramp_sum;
            end
        end else begin
            ramp_acc_reg <= 32'h0;
            vscale_reg <= 11'h000;
        end
    end

    assign o_restart_freq = held_reg;
    assign o_voltage_scale = vscale_reg;
    assign o_restart_active = state_reg[1] | state_reg[2] | state_reg[3];
    assign o_restart_blocked = state_reg[4];

    a_ramp_rises: assert property
        (state_reg == drive_mon_pkg::ST_RAMP && supply_reg |=>
        o_voltage_scale >= $past(o_voltage_scale))
        else $error("restart voltage fell during ramp");
    a_ramp_hold_freq: assert property
        (state_reg == drive_mon_pkg::ST_RAMP |=> $stable(o_restart_freq))
        else $error("held frequency moved during ramp");
    a_long_loss_zero: assert property (long_reg &&
        state_reg != drive_mon_pkg::ST_RUN |-> o_restart_freq == 16'h0000)
        else $error("held frequency kept after long loss");
    a_unset_blocks: assert property
        (state_reg == drive_mon_pkg::ST_LOST && supply_reg &&
        i_coast_wait_time == `CFG_UNSET |=>
        state_reg == drive_mon_pkg::ST_BLOCK ##1 o_voltage_scale == 11'h000)
        else $error("restart not disabled by unset coast time");
    a_coast_wait: assert property
        (state_reg == drive_mon_pkg::ST_COAST && !coast_done |=>
        state_reg != drive_mon_pkg::ST_RAMP)
        else $error("ramp began before coast time");

endmodule : drive_freq_monitor_restart

// file: test/stage_model.sv
/*
 * power stage and meter model: measurements, pins, update strobe and
 * a half-period meter on the monitor pulse. assumes the bench sets
 * meas, supply_ok and contact shortly after a clock edge.
 */
`timescale 1ns/10ps
module stage_model #(
    parameter int UPDATE_GAP = 4
) (
    input wire logic i_clk,
    input wire logic i_pulse,
    output drive_mon_pkg::drive_meas_t o_meas,
    output logic o_update,
    output logic o_supply_ok_pin,
    output logic o_contact_pin
);
    // ****
    // state set by the bench
    // ****
    drive_mon_pkg::drive_meas_t meas = '0;
    logic supply_ok = 1'b1;
    logic contact = 1'b0;
    logic pulse_last = 1'b0;
    int gap_cnt = 0;
    int half_cnt = 0;
    int half_len = 0;
    int n_edges = 0;
    assign o_meas = meas;
    assign o_supply_ok_pin = supply_ok;
    assign o_contact_pin = contact;
    assign o_update = (gap_cnt == 0);
    // ****
    // update strobe and pulse meter
    // ****
    always @(posedge i_clk) begin
        gap_cnt <= (gap_cnt == UPDATE_GAP - 1) ? 0 : gap_cnt + 1;
        pulse_last <= i_pulse;
        half_cnt <= (i_pulse != pulse_last) ? 1 : half_cnt + 1;
        if (i_pulse != pulse_last) begin
            half_len <= half_cnt;
            n_edges <= n_edges + 1;
        end
    end
endmodule : stage_model

// file: test/drive_freq_monitor_restart_tb.sv
/*
 * bench of the supervisory logic: flags, second set, monitor, restart.
 * assumes stage_model supplies measurements, pins and updates.
 */
`timescale 1ns/10ps
`include "drive_mon_map.svh"
module drive_freq_monitor_restart_tb;
    localparam int unsigned TC = 40;
    logic i_clk, i_srst, i_update, i_vector_mode_select, i_shared_term_pin;
    logic i_term_as_second_set, i_monitor_source_select, i_supply_ok_pin;
    logic i_rating_large, i_restart_clear;
    logic [7:0] i_arrival_band_width;
    logic [15:0] i_fwd_sense_level, i_rev_sense_level, i_alt_accel_time;
    logic [15:0] i_alt_decel_time, i_alt_torque_boost, i_alt_base_freq;
    logic [15:0] i_ramp_reference_freq, i_freq_monitor_reference;
    logic [15:0] i_current_monitor_reference, i_coast_wait_time;
    logic [15:0] i_voltage_ramp_time, o_ramp_reference_freq, o_restart_freq;
    drive_mon_pkg::drive_meas_t i_meas;
    drive_mon_pkg::drive_set_t i_main_set, o_drive_set;
    logic o_freq_arrived_flag_o, o_freq_arrived_flag_oe, o_freq_detect_flag_o;
    logic o_freq_detect_flag_oe, o_second_set_select, o_output_shutoff_in;
    logic o_pulse_monitor_out, o_restart_active, o_restart_blocked;
    logic [10:0] o_voltage_scale;
    int n_fail = 0;
    int checks_done = 0;
    stage_model i_stage_model (.i_clk, .i_pulse(o_pulse_monitor_out),
        .o_meas(i_meas), .o_update(i_update),
        .o_supply_ok_pin(i_supply_ok_pin), .o_contact_pin(i_shared_term_pin));
    drive_freq_monitor_restart #(.TENTH_CYCLES(TC))
        i_drive_freq_monitor_restart (.i_clk, .i_srst, .i_update, .i_meas,
        .i_arrival_band_width, .i_fwd_sense_level, .i_rev_sense_level,
        .i_main_set, .i_alt_accel_time, .i_alt_decel_time,
        .i_alt_torque_boost, .i_alt_base_freq, .i_ramp_reference_freq,
        .i_vector_mode_select, .i_shared_term_pin, .i_term_as_second_set,
        .i_monitor_source_select, .i_freq_monitor_reference,
        .i_current_monitor_reference, .i_supply_ok_pin, .i_rating_large,
        .i_coast_wait_time, .i_voltage_ramp_time, .i_restart_clear,
        .o_freq_arrived_flag_o, .o_freq_arrived_flag_oe, .o_freq_detect_flag_o,
        .o_freq_detect_flag_oe, .o_second_set_select, .o_output_shutoff_in,
        .o_drive_set, .o_ramp_reference_freq, .o_pulse_monitor_out,
        .o_restart_freq, .o_voltage_scale, .o_restart_active,
        .o_restart_blocked);
    // ****
    // tasks
    // ****
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : step
    task automatic chk(input logic [15:0] got, lo, hi);
        checks_done++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask : chk
    task automatic flag(input logic [15:0] f, input logic rev, det, arr);
        i_stage_model.meas.out_freq = f;
        i_stage_model.meas.reverse = rev;
        step(9);
        chk(o_freq_detect_flag_oe, det, det);
        chk(o_freq_arrived_flag_oe, arr, arr);
    endtask : flag
    task automatic half_period(input logic [15:0] lo, hi);
        int e0;
        e0 = i_stage_model.n_edges;
        for (int k = 0; k < 50000 && i_stage_model.n_edges < e0 + 3; k++)
            step(1);
        if (i_stage_model.n_edges < e0 + 3) begin
            n_fail++;
            finish_test();
        end
        chk(16'(i_stage_model.half_len), lo, hi);
    endtask : half_period
    task automatic loss(input int n);
        i_stage_model.meas.out_freq = 16'h0FA0;
        i_stage_model.supply_ok = 1'b0;
        step(8);
        i_stage_model.meas.out_freq = '0;
        step(n - 8);
    endtask : loss
    task automatic wait_run(input int bound);
        int k;
        for (k = 0; k < bound && o_restart_active !== 1'b0; k++) step(1);
        if (k == bound) begin
            n_fail++;
            finish_test();
        end
    endtask : wait_run
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // ****
    // main sequence
    // ****
    initial begin
        {i_arrival_band_width, i_fwd_sense_level} = {8'h0A, 16'h0BB8};
        {i_srst, i_rev_sense_level} = {1'b1, `CFG_UNSET};
        i_main_set = {16'h0064, 16'h00C8, 16'h001E, 16'h1770};
        {i_alt_accel_time, i_alt_decel_time} = {16'h012C, `CFG_UNSET};
        {i_alt_torque_boost, i_alt_base_freq} = {16'h0028, 16'h1388};
        {i_ramp_reference_freq, i_vector_mode_select} = {16'h1770, 1'b0};
        {i_term_as_second_set, i_monitor_source_select} = 2'h0;
        {i_freq_monitor_reference, i_current_monitor_reference} = 32'h177003E8;
        {i_rating_large, i_restart_clear} = 2'h0;
        {i_coast_wait_time, i_voltage_ramp_time} = {16'h0001, 16'h0002};
        i_stage_model.meas.set_freq = 16'h1388;
        step(6);
        i_srst = 1'b0;
        flag(16'h0C1C, 1'b0, 1'b1, 1'b0);
        flag(16'h0B54, 1'b0, 1'b0, 1'b0);
        flag(16'h0C1C, 1'b1, 1'b1, 1'b0);
        i_rev_sense_level = 16'h1388;
        flag(16'h0C1C, 1'b1, 1'b0, 1'b0);
        flag(16'h13EC, 1'b1, 1'b1, 1'b1);
        flag(16'h157C, 1'b0, 1'b1, 1'b1);
        flag(16'h157D, 1'b0, 1'b1, 1'b0);
        flag(16'h1194, 1'b0, 1'b1, 1'b1);
        i_arrival_band_width = 8'h00;
        flag(16'h1388, 1'b0, 1'b1, 1'b1);
        flag(16'h1389, 1'b0, 1'b1, 1'b0);
        $display("test flags done");
        i_stage_model.contact = 1'b1;
        step(8);
        chk(o_output_shutoff_in, 1, 1);
        chk(o_second_set_select, 0, 0);
        i_term_as_second_set = 1'b1;
        step(8);
        chk(o_drive_set.decel_time, 16'h012C, 16'h012C);
        chk(o_drive_set.base_freq, 16'h1388, 16'h1388);
        chk(o_ramp_reference_freq, 16'h1770, 16'h1770);
        {i_alt_decel_time, i_vector_mode_select} = {16'h02BC, 1'b1};
        step(3);
        chk(o_drive_set.decel_time, 16'h02BC, 16'h02BC);
        chk(o_drive_set.torque_boost | o_drive_set.base_freq, 0, 0);
        {i_stage_model.contact, i_vector_mode_select} = 2'h0;
        step(8);
        chk(o_drive_set.decel_time, 16'h00C8, 16'h00C8);
        $display("test second set done");
        i_stage_model.meas.out_freq = 16'h1770;
        half_period(16'h363F, 16'h3643);
        i_stage_model.meas.out_current = 16'h07D0;
        i_monitor_source_select = 1'b1;
        half_period(16'h208B, 16'h2090);
        $display("test monitor done");
        step(4);
        loss(30);
        chk(o_voltage_scale | {10'h0, ~o_restart_active}, 0, 0);
        chk(o_restart_freq, 16'h0FA0, 16'h0FA0);
        i_stage_model.supply_ok = 1'b1;
        step(30);
        chk(o_voltage_scale, 0, 0);
        step(60);
        chk(o_voltage_scale, 11'h001, 11'h3FF);
        wait_run(150);
        chk(o_voltage_scale, 11'h400, 11'h400);
        loss(120);
        chk(o_restart_freq, 0, 0);
        i_stage_model.supply_ok = 1'b1;
        wait_run(300);
        i_coast_wait_time = 16'h0000;
        for (int r = 0; r < 2; r++) begin
            i_rating_large = 1'(r);
            loss(20);
            i_stage_model.supply_ok = 1'b1;
            step((r + 1) * 5 * TC - 20);
            chk(o_voltage_scale, 0, 0);
            wait_run(200);
        end
        i_coast_wait_time = `CFG_UNSET;
        loss(20);
        i_stage_model.supply_ok = 1'b1;
        step(10);
        chk(o_restart_blocked, 1, 1);
        i_restart_clear = 1'b1;
        step(2);
        i_restart_clear = 1'b0;
        step(4);
        chk(o_restart_blocked, 0, 0);
        $display("test restart done");
        finish_test();
    end
endmodule : drive_freq_monitor_restart_tb
